// file: bar_vector_plot.sv
// vertical bar graph and vector plot byte interpreter with block drawing engine
`timescale 1ns/100ps
module bar_vector_plot
  import plot_pkg::*;
(
  input wire logic clk, // 25 MHz system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic byte_valid, // host offers a byte
  input wire logic [7:0] byte_data, // offered byte
  output logic byte_ready, // byte taken when valid and ready
  output logic plot_on, // general plot mode active
  output logic pix_valid, // one block to intensify this cycle
  output pix_t pix // block position
);
  pstate_t state;
  coord_t start_row, bar_col, bar_top, vx0, x1, y1;
  logic inc_pend;
  logic [3:0] inc_nib;
  logic go;
  pix_t ln_s, ln_e;
  logic busy, eng_done;
  coord_t cx, cy;
  logic signed [9:0] dxs, dys, err;
  logic sgx, sgy;
  logic acc;
  logic is_code;
  logic [7:0] d;

  assign acc = ce && byte_valid && byte_ready;
  assign d = byte_data;
  assign is_code = d >= CODE_FIRST;

  // relative step of one coordinate, wrapping on the grid
  function automatic coord_t step(input logic [1:0] f, input coord_t v);
    coord_t r;
    r = v;
    if (f == STEP_NEG) r = v - 7'h01;
    else if (f == STEP_POS) r = v + 7'h01;
    return r;
  endfunction

  // submode selected by a code byte
  function automatic pstate_t pick(input logic [7:0] c);
    pstate_t r;
    case (c)
      CODE_PT_X: r = s_px;
      CODE_PT_Y: r = s_py;
      CODE_BAR_ROW: r = s_vrow;
      CODE_BAR_COL: r = s_vcol;
      CODE_BAR_TOP: r = s_vtop;
      CODE_BAR_INC: r = s_vinc;
      CODE_VEC_X0: r = s_vx0;
      CODE_VEC_Y0: r = s_vy0;
      CODE_CHAR: r = s_char;
      default: r = s_other;
    endcase
    return r;
  endfunction

  // ==========================================================
  // byte interpreter
  // the stream is held off while a bar or line is drawn, so no byte buffer is needed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= s_off;
      plot_on <= 1'b0;
      byte_ready <= 1'b1;
      go <= 1'b0;
      inc_pend <= 1'b0;
      inc_nib <= 4'h0;
      start_row <= COORD_RST;
      bar_col <= COORD_RST;
      bar_top <= COORD_RST;
      vx0 <= COORD_RST;
      x1 <= COORD_RST;
      y1 <= COORD_RST;
      ln_s <= '0;
      ln_e <= '0;
    end else if (ce) begin
      go <= 1'b0;
      if (eng_done && inc_pend) begin
        // second bar of an incremental byte
        bar_col <= step(inc_nib[3:2], bar_col);
        bar_top <= step(inc_nib[1:0], bar_top);
        ln_s <= '{x: step(inc_nib[3:2], bar_col), y: start_row};
        ln_e <= '{x: step(inc_nib[3:2], bar_col), y: step(inc_nib[1:0], bar_top)};
        go <= 1'b1;
        inc_pend <= 1'b0;
      end else if (eng_done) begin
        byte_ready <= 1'b1;
      end else if (acc) begin
        if (state == s_off) begin
          if (d == CODE_PLOT) begin
            state <= s_gen;
            plot_on <= 1'b1;
          end
        end else if (d == CODE_ESC) begin
          state <= s_off;
          plot_on <= 1'b0;
        end else if (state == s_char) begin
          state <= s_char;
        end else if (is_code) begin
          state <= pick(d);
        end else begin
          case (state)
            s_px: begin
              x1 <= d[6:0];
              state <= s_py;
            end
            s_py: begin
              y1 <= d[6:0];
              ln_s <= '{x: x1, y: d[6:0]};
              ln_e <= '{x: x1, y: d[6:0]};
              go <= 1'b1;
              byte_ready <= 1'b0;
              state <= s_px;
            end
            s_vrow: begin
              start_row <= d[6:0];
              state <= s_vcol;
            end
            s_vcol: begin
              bar_col <= d[6:0];
              state <= s_vtop;
            end
            s_vtop: begin
              bar_top <= d[6:0];
              ln_s <= '{x: bar_col, y: start_row};
              ln_e <= '{x: bar_col, y: d[6:0]};
              go <= 1'b1;
              byte_ready <= 1'b0;
              state <= s_vcol;
            end
            s_vinc: begin
              bar_col <= step(d[7:6], bar_col);
              bar_top <= step(d[5:4], bar_top);
              ln_s <= '{x: step(d[7:6], bar_col), y: start_row};
              ln_e <= '{x: step(d[7:6], bar_col), y: step(d[5:4], bar_top)};
              inc_nib <= d[3:0];
              inc_pend <= 1'b1;
              go <= 1'b1;
              byte_ready <= 1'b0;
            end
            s_vx0: begin
              vx0 <= d[6:0];
              state <= s_vy0;
            end
            s_vy0: begin
              ln_s <= '{x: x1, y: y1};
              ln_e <= '{x: vx0, y: d[6:0]};
              x1 <= vx0;
              y1 <= d[6:0];
              go <= 1'b1;
              byte_ready <= 1'b0;
              state <= s_vx0;
            end
            default: state <= state;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // block drawing engine: integer best-fit line, one block per cycle
  logic signed [10:0] e2;
  assign e2 = {err, 1'b0};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy <= 1'b0;
      eng_done <= 1'b0;
      pix_valid <= 1'b0;
      pix <= '0;
      cx <= COORD_RST;
      cy <= COORD_RST;
      dxs <= 10'sh000;
      dys <= 10'sh000;
      err <= 10'sh000;
      sgx <= 1'b0;
      sgy <= 1'b0;
    end else if (ce) begin
      pix_valid <= 1'b0;
      eng_done <= 1'b0;
      if (go) begin
        // distances from the endpoints; a bar has zero width so only cy moves
        cx <= ln_s.x;
        cy <= ln_s.y;
        sgx <= ln_e.x < ln_s.x;
        sgy <= ln_e.y < ln_s.y;
        dxs <= (ln_e.x >= ln_s.x) ? {3'b000, ln_e.x - ln_s.x} : {3'b000, ln_s.x - ln_e.x};
        dys <= (ln_e.y >= ln_s.y) ? -{3'b000, ln_e.y - ln_s.y} : -{3'b000, ln_s.y - ln_e.y};
        err <= ((ln_e.x >= ln_s.x) ? {3'b000, ln_e.x - ln_s.x} : {3'b000, ln_s.x - ln_e.x})
             - ((ln_e.y >= ln_s.y) ? {3'b000, ln_e.y - ln_s.y} : {3'b000, ln_s.y - ln_e.y});
        busy <= 1'b1;
      end else if (busy) begin
        pix_valid <= 1'b1;
        pix <= '{x: cx, y: cy};
        if (cx == ln_e.x && cy == ln_e.y) begin
          busy <= 1'b0;
          eng_done <= 1'b1;
        end else begin
          err <= err + ((e2 >= 11'(dys)) ? dys : 10'sh000) + ((e2 <= 11'(dxs)) ? dxs : 10'sh000);
          if (e2 >= 11'(dys)) cx <= sgx ? cx - 7'h01 : cx + 7'h01;
          if (e2 <= 11'(dxs)) cy <= sgy ? cy - 7'h01 : cy + 7'h01;
        end
      end
    end
  end

  // ==========================================================
  // checks
  logic bar_draw;
  always_ff @(posedge clk) begin
    if (!nrst) bar_draw <= 1'b0;
    else if (ce && go) bar_draw <= ln_s.x == ln_e.x && (state == s_vcol || state == s_vinc);
  end

  a_row_entry: assert property (@(posedge clk) disable iff (!nrst)
    acc && d == CODE_BAR_ROW && state != s_off && state != s_char |=> state == s_vrow)
    else $error("code 246 did not select start row");
  a_row_fold: assert property (@(posedge clk) disable iff (!nrst)
    acc && state == s_vrow && !is_code |=> start_row == $past(d[6:0]) && state == s_vcol)
    else $error("start row not folded and stored");
  a_col_advance: assert property (@(posedge clk) disable iff (!nrst)
    acc && state == s_vcol && !is_code |=> state == s_vtop && bar_col == $past(d[6:0]))
    else $error("column byte did not lead to bar top");
  // a low clock enable stretches a draw, so frozen cycles end the timed attempts
  a_bar_draws: assert property (@(posedge clk) disable iff (!nrst || !ce)
    acc && state == s_vtop && !is_code && d != CODE_ESC |=> !byte_ready ##[1:4] pix_valid)
    else $error("bar top byte did not start drawing");
  a_bar_width: assert property (@(posedge clk) disable iff (!nrst)
    pix_valid && bar_draw |-> pix.x == bar_col)
    else $error("bar wider than one block");
  a_row_kept: assert property (@(posedge clk) disable iff (!nrst)
    state == s_off |=> $stable(start_row))
    else $error("start row lost outside plot mode");
  a_escape_ends: assert property (@(posedge clk) disable iff (!nrst)
    acc && state != s_off && d == CODE_ESC |=> !plot_on && state == s_off)
    else $error("escape did not end plot mode");
  a_inc_decode: assert property (@(posedge clk) disable iff (!nrst)
    acc && state == s_vinc && d[7:6] == STEP_POS |=> bar_col == $past(bar_col) + 7'h01)
    else $error("positive step not applied");
  a_vec_return: assert property (@(posedge clk) disable iff (!nrst || !ce)
    acc && state == s_vy0 && !is_code && d != CODE_ESC
    |=> !byte_ready ##[1:300] (byte_ready && state == s_vx0))
    else $error("vector did not finish back in X0 submode");
  a_vec_chain: assert property (@(posedge clk) disable iff (!nrst)
    acc && state == s_vy0 && !is_code |=> x1 == $past(vx0) && y1 == $past(d[6:0]))
    else $error("vector endpoint not chained");
  a_x0_advance: assert property (@(posedge clk) disable iff (!nrst)
    acc && state == s_vx0 && !is_code |=> state == s_vy0)
    else $error("X0 byte did not lead to Y0");

  c_bar: cover property (@(posedge clk) disable iff (!nrst) bar_draw && eng_done);
  c_inc_two: cover property (@(posedge clk) disable iff (!nrst) inc_pend && eng_done);
  c_vector: cover property (@(posedge clk) disable iff (!nrst)
    state == s_vx0 && eng_done && !bar_draw);
  c_reentry: cover property (@(posedge clk) disable iff (!nrst)
    acc && state == s_gen && d == CODE_BAR_COL);
endmodule

// file: bar_vector_plot_bench.sv
// self-checking bench for the bar and vector plot interpreter
`timescale 1ns/100ps
module bar_vector_plot_bench
  import plot_pkg::*;
;
  typedef struct {
    logic [7:0] d;
    int n, fx, fy, lx, ly;
  } row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic byte_valid, byte_ready, plot_on, pix_valid;
  logic [7:0] byte_data;
  pix_t pix, first, last;
  int cnt = 0;
  int stuck;
  int bad_count = 0;
  int check_count = 0;
  // ==========================================================
  // byte, blocks expected, first block, last block
  row_t rows[] = '{
    '{8'h02,0,0,0,0,0}, '{8'hF6,0,0,0,0,0}, '{8'h82,0,0,0,0,0},
    '{8'h05,0,0,0,0,0}, '{8'h07,6,5,2,5,7}, '{8'h06,0,0,0,0,0},
    '{8'h00,3,6,2,6,0}, '{8'hF4,0,0,0,0,0}, '{8'h04,3,6,2,6,4},
    '{8'hF5,0,0,0,0,0}, '{8'h0A,0,0,0,0,0}, '{8'h03,2,10,2,10,3},
    '{8'hFF,0,0,0,0,0}, '{8'h05,0,0,0,0,0}, '{8'h02,0,0,0,0,0},
    '{8'hF5,0,0,0,0,0}, '{8'h0C,0,0,0,0,0}, '{8'h02,1,12,2,12,2},
    '{8'hFD,0,0,0,0,0}, '{8'h00,0,0,0,0,0}, '{8'h00,1,0,0,0,0},
    '{8'hF2,0,0,0,0,0}, '{8'h03,0,0,0,0,0}, '{8'h00,4,0,0,3,0},
    '{8'h03,0,0,0,0,0}, '{8'h03,4,3,0,3,3}, '{8'hF3,0,0,0,0,0},
    '{8'h99,5,13,2,14,0}, '{8'h3F,6,14,2,14,0}, '{8'hF6,0,0,0,0,0},
    '{8'h81,0,0,0,0,0}, '{8'h05,0,0,0,0,0}, '{8'hF0,0,0,0,0,0},
    '{8'hF5,0,0,0,0,0}, '{8'h01,0,0,0,0,0}, '{8'h03,3,1,1,1,3}
  };

  // ==========================================================
  // 25 MHz clock
  always #20 clk = ~clk;

  plot_host host_u (.clk(clk), .byte_ready(byte_ready), .byte_valid(byte_valid),
    .byte_data(byte_data), .stuck(stuck));

  bar_vector_plot dut_u (.clk(clk), .nrst(nrst), .ce(ce), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .plot_on(plot_on),
    .pix_valid(pix_valid), .pix(pix));

  // ==========================================================
  // collect drawn blocks; frozen cycles count nothing
  always @(posedge clk) begin
    if (pix_valid === 1'b1 && ce === 1'b1) begin
      if (cnt == 0) first = pix;
      last = pix;
      cnt++;
    end
  end

  function automatic pix_t xy(input int x, input int y);
    return {7'(x), 7'(y)};
  endfunction

  task automatic miss(input string m);
    bad_count++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // wait out a draw under a bound; too long is a hang
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (byte_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      miss("draw never ended");
      tally_and_finish();
    end
    @(posedge clk);
  endtask

  // block count and last block of the draw made by the latest byte
  task automatic chk_draw(input int n, input int lx, input int ly);
    check_count++;
    if (cnt != n || (n > 0 && last !== xy(lx, ly))) miss("draw after reset");
  endtask

  task automatic put(input logic [7:0] d, input int idle);
    cnt = 0;
    host_u.send(d, idle);
    settle();
  endtask

  // ==========================================================
  // table first, then exit, clock enable and reset by hand
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      put(rows[i].d, i % 2);
      check_count++;
      if (cnt != rows[i].n) miss("block count");
      check_count++;
      if (rows[i].n > 0 && (first !== xy(rows[i].fx, rows[i].fy) ||
          last !== xy(rows[i].lx, rows[i].ly))) miss("draw ends");
    end
    $display("table test done");
    put(8'hFF, 0);
    check_count++;
    if (plot_on !== 1'b0) miss("plot mode still on");
    put(8'h02, 0);
    put(8'hF6, 0);
    put(8'h00, 0);
    put(8'h00, 0);
    cnt = 0;
    host_u.send(8'h08, 0);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    check_count++;
    if (cnt != 0) miss("drew while frozen");
    ce <= 1'b1;
    settle();
    check_count++;
    if (cnt != 9 || last !== xy(0, 8)) miss("bar after freeze");
    $display("freeze test done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check_count++;
    if (byte_ready !== 1'b1 || plot_on !== 1'b0 || pix_valid !== 1'b0 || pix !== 14'h0000)
      miss("reset values");
    @(posedge clk);
    nrst <= 1'b1;
    // character plot swallows bar codes; escape still leaves plot mode
    put(8'h02, 0);
    put(8'hFE, 0);
    put(8'hF5, 0);
    put(8'h03, 0);
    put(8'h07, 1);
    chk_draw(0, 0, 0);
    put(8'hFF, 0);
    put(8'h02, 0);
    put(8'hF1, 0);
    put(8'h05, 0);
    chk_draw(6, 0, 5);
    put(8'hFC, 0);
    put(8'h04, 0);
    chk_draw(1, 0, 4);
    put(8'hF5, 0);
    put(8'h03, 0);
    put(8'h02, 0);
    chk_draw(3, 3, 2);
    $display("reset test done");
    if (stuck != 0) miss("byte never taken");
    tally_and_finish();
  end
endmodule

// file: plot_host.sv
// host model that offers plot command bytes one at a time
`timescale 1ns/100ps
module plot_host (
  input wire logic clk, // system clock
  input wire logic byte_ready, // interpreter can take a byte
  output logic byte_valid, // byte offered
  output logic [7:0] byte_data, // offered byte
  output int stuck // offers that were never taken
);
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'hA5;
    stuck = 0;
  end
  // ==========================================================
  // offer one byte and hold it until the edge that takes it;
  // idle data is inverted so a stale byte is never seen as new
  task automatic send(input logic [7:0] d, input int idle);
    int n;
    n = 0;
    repeat (idle) @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (byte_ready !== 1'b1 && n < 300);
    if (n >= 300) stuck++;
    byte_valid <= 1'b0;
    byte_data <= ~d;
  endtask
endmodule

// file: plot_pkg.sv
// constants and types shared by the vertical bar and vector plot interpreter
package plot_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CODE_PLOT = 8'h02;
  localparam logic [7:0] CODE_ESC = 8'hFF;
  localparam logic [7:0] CODE_CHAR = 8'hFE;
  localparam logic [7:0] CODE_PT_X = 8'hFD;
  localparam logic [7:0] CODE_PT_Y = 8'hFC;
  localparam logic [7:0] CODE_BAR_ROW = 8'hF6;
  localparam logic [7:0] CODE_BAR_COL = 8'hF5;
  localparam logic [7:0] CODE_BAR_TOP = 8'hF4;
  localparam logic [7:0] CODE_BAR_INC = 8'hF3;
  localparam logic [7:0] CODE_VEC_X0 = 8'hF2;
  localparam logic [7:0] CODE_VEC_Y0 = 8'hF1;
  localparam logic [7:0] CODE_FIRST = 8'hF0;
  // ==========================================================
  // grid and step coding
  localparam int COORD_W = 7;
  localparam logic [1:0] STEP_NEG = 2'h1;
  localparam logic [1:0] STEP_POS = 2'h2;
  localparam logic [COORD_W-1:0] COORD_RST = 7'h00;

  typedef logic [COORD_W-1:0] coord_t;

  // one plot block on the 128 by 128 grid
  typedef struct packed {
    coord_t x;
    coord_t y;
  } pix_t;

  typedef enum {
    s_off, s_gen, s_px, s_py, s_vrow, s_vcol, s_vtop, s_vinc,
    s_vx0, s_vy0, s_char, s_other
  } pstate_t;
endpackage
